// ### rtl/cpu_instruction_decode_timing.sv
// instruction field decode, cycle count and read-modify-write strobes
`timescale 1ns/10ps
`include "decode_regs.svh"
// Notes on behaviour
// - each 14-bit word carries opcode and all its operands
// - all instructions take one instruction cycle except the listed classes
// - call and accumulator call take two instruction cycles
// - plain return, literal return and interrupt return take two cycles
// - jumps, offset jump, bit skips and count skips take two cycles
// - file address field picks location 0x00 to 0x7f in the bank
// - destination bit 0 writes accumulator, 1 writes the file register
// - bit field picks one bit of an 8-bit file register
// - pointer number field picks pointer 0 or 1
// - mode field picks pre/post increment/decrement pointer update
// - indirect access through a pointer into program memory adds a cycle
// - one instruction cycle is four oscillator clocks
// - file instructions read, modify, then store per opcode or destination
// - the file read happens even for write-only instructions
module cpu_instruction_decode_timing (
    // clocking
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // fetched word and pointer state from the core
    input wire decode_pkg::word_t instr_word,
    input wire logic [1:0] ptr_in_prog,
    // decoded instruction
    output decode_pkg::word_t instr_q,
    output logic fetch_q,
    output logic [6:0] file_addr_q,
    output logic [2:0] bit_pos_q,
    output logic [7:0] bit_mask_q,
    output logic [7:0] literal_q,
    output logic [10:0] jump_lit_q,
    output logic dest_file_q,
    output logic ptr_num_q,
    output logic [1:0] ptr_mode_q,
    output decode_pkg::cycles_t cycles_q,
    // execution strobes
    output logic flush_q,
    output logic file_rd_q,
    output logic file_wr_q,
    output logic acc_wr_q
);
    timing_if ti ();

    cycle_timer u_timer (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .ti(ti)
    );

    function automatic logic names_file(input decode_pkg::word_t w);
        names_file = (w[13:12] == `OP_BIT_CLS) ||
            ((w[13:12] == `OP_BYTE_CLS) && ((w[13:8] != `OP_MISC) || w[`D_BIT]));
    endfunction

    function automatic logic is_ptr_move(input decode_pkg::word_t w);
        is_ptr_move = (w[13:4] == `OP_PTR_MOVE);
    endfunction

    function automatic logic is_ptr_offs(input decode_pkg::word_t w);
        is_ptr_offs = (w[13:8] == `OP_PTR_OFFS);
    endfunction

    function automatic logic is_two_cycle(input decode_pkg::word_t w);
        is_two_cycle = (w[13:11] == `OP_CALL_TOP) || (w == `OP_CALL_ACC)
            || (w == `OP_RET_PLAIN) || (w == `OP_RET_INT) || (w[13:8] == `OP_RET_LIT)
            || (w[13:11] == `OP_JUMP_TOP) || (w[13:9] == `OP_REL_JUMP)
            || (w == `OP_JUMP_ACC) || (w[13:10] == `OP_SKIP_CLR)
            || (w[13:10] == `OP_SKIP_SET) || (w[13:8] == `OP_DEC_SKIP)
            || (w[13:8] == `OP_INC_SKIP);
    endfunction

    // pointer selected by the word, meaningful only when it uses one
    function automatic logic ptr_of(input decode_pkg::word_t w);
        if (is_ptr_move(w)) begin
            ptr_of = w[`PTR_MM_BIT];
        end else if (is_ptr_offs(w)) begin
            ptr_of = w[`PTR_K_BIT];
        end else begin
            ptr_of = w[`F_LO];
        end
    endfunction

    function automatic logic uses_ptr(input decode_pkg::word_t w);
        uses_ptr = is_ptr_move(w) || is_ptr_offs(w) ||
            (names_file(w) && (w[`INDIRECT_HI:`INDIRECT_LO] == `INDIRECT_BASE));
    endfunction

    decode_pkg::step_e st_q, st_d;
    decode_pkg::word_t instr_d;
    logic fetch_d, flush_d, file_rd_d, file_wr_d, acc_wr_d;
    logic [6:0] file_addr_d;
    logic [2:0] bit_pos_d;
    logic [7:0] bit_mask_d, literal_d;
    logic [10:0] jump_lit_d;
    logic dest_file_d, ptr_num_d, indir_prog_q, indir_prog_d;
    logic [1:0] ptr_mode_d;
    decode_pkg::cycles_t cycles_d;
    logic boundary, xtra;

    always_comb begin
        boundary = (ti.phase == `PHASE_LAST);
        xtra = uses_ptr(instr_word) && ptr_in_prog[ptr_of(instr_word)];
        st_d = st_q;
        instr_d = instr_q;
        file_addr_d = file_addr_q;
        bit_pos_d = bit_pos_q;
        bit_mask_d = bit_mask_q;
        literal_d = literal_q;
        jump_lit_d = jump_lit_q;
        dest_file_d = dest_file_q;
        ptr_num_d = ptr_num_q;
        ptr_mode_d = ptr_mode_q;
        cycles_d = cycles_q;
        indir_prog_d = indir_prog_q;
        fetch_d = 1'b0;
        ti.load = 1'b0;
        ti.cycles = `CYC_ONE;
        if (boundary) begin
            if (ti.remain_zero) begin
                st_d = decode_pkg::ST_EXEC;
                fetch_d = 1'b1;
                instr_d = instr_word;
                file_addr_d = instr_word[`F_HI:`F_LO];
                bit_pos_d = instr_word[`B_HI:`B_LO];
                bit_mask_d = `MASK_ONE << instr_word[`B_HI:`B_LO];
                literal_d = instr_word[`K8_HI:0];
                jump_lit_d = instr_word[`K11_HI:0];
                dest_file_d = instr_word[`D_BIT];
                ptr_num_d = ptr_of(instr_word);
                ptr_mode_d = is_ptr_move(instr_word) ? instr_word[`MM_HI:`MM_LO] : 2'h0;
                indir_prog_d = xtra;
                ti.load = 1'b1;
                ti.cycles = (is_two_cycle(instr_word) ? `CYC_TWO : `CYC_ONE)
                    + {1'b0, xtra};
                cycles_d = ti.cycles;
            end else begin
                st_d = decode_pkg::ST_FLUSH;
            end
        end
        flush_d = (st_d == decode_pkg::ST_FLUSH);
        // strobes only in the executing cycle, never in an added one
        file_rd_d = (st_q == decode_pkg::ST_EXEC) && (ti.phase == `PHASE_RD_SET)
            && names_file(instr_q);
        file_wr_d = 1'b0;
        acc_wr_d = 1'b0;
        if ((st_q == decode_pkg::ST_EXEC) && (ti.phase == `PHASE_WR_SET)) begin
            if (instr_q[13:12] == `OP_BIT_CLS) begin
                file_wr_d = (instr_q[11] == `OP_BIT_WR);
            end else if (names_file(instr_q)) begin
                file_wr_d = instr_q[`D_BIT];
                acc_wr_d = !instr_q[`D_BIT];
            end
        end
    end

    // a freeze on ce holds every strobe as well, so the core sees it again on resume
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= decode_pkg::ST_FLUSH;
            instr_q <= 14'h0000;
            fetch_q <= 1'b0;
            file_addr_q <= 7'h00;
            bit_pos_q <= 3'h0;
            bit_mask_q <= 8'h00;
            literal_q <= 8'h00;
            jump_lit_q <= 11'h000;
            dest_file_q <= 1'b0;
            ptr_num_q <= 1'b0;
            ptr_mode_q <= 2'h0;
            cycles_q <= 2'h0;
            indir_prog_q <= 1'b0;
            flush_q <= 1'b1;
            file_rd_q <= 1'b0;
            file_wr_q <= 1'b0;
            acc_wr_q <= 1'b0;
        end else if (ce) begin
            st_q <= st_d;
            instr_q <= instr_d;
            fetch_q <= fetch_d;
            file_addr_q <= file_addr_d;
            bit_pos_q <= bit_pos_d;
            bit_mask_q <= bit_mask_d;
            literal_q <= literal_d;
            jump_lit_q <= jump_lit_d;
            dest_file_q <= dest_file_d;
            ptr_num_q <= ptr_num_d;
            ptr_mode_q <= ptr_mode_d;
            cycles_q <= cycles_d;
            indir_prog_q <= indir_prog_d;
            flush_q <= flush_d;
            file_rd_q <= file_rd_d;
            file_wr_q <= file_wr_d;
            acc_wr_q <= acc_wr_d;
        end
    end

    // a ce freeze may sit between read and write, so remember the read instead of counting ticks
    logic rd_seen_q, rd_seen_d;

    always_comb begin
        rd_seen_d = file_rd_q || (rd_seen_q && !fetch_q);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_seen_q <= 1'b0;
        end else if (ce) begin
            rd_seen_q <= rd_seen_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn || !ce);

    sequence one_exec;
        ##4 fetch_q;
    endsequence
    sequence one_flush;
        ##4 (flush_q && !fetch_q);
    endsequence

    a_single_cycle: assert property (fetch_q && cycles_q == 2'h1 |-> one_exec)
        else $error("one-cycle instruction did not end after four clocks");
    a_two_cycle: assert property (fetch_q && cycles_q == 2'h2 |-> one_flush ##0 one_exec)
        else $error("two-cycle instruction timing wrong");
    a_call_count: assert property (fetch_q && instr_q[13:11] == `OP_CALL_TOP
        |-> cycles_q >= 2'h2)
        else $error("call not counted as two cycles");
    a_return_count: assert property (fetch_q && instr_q == `OP_RET_PLAIN
        |-> cycles_q == 2'h2 ##4 flush_q)
        else $error("return not two cycles");
    a_indirect_extra: assert property (fetch_q && indir_prog_q && cycles_q == 2'h2
        |-> ##4 flush_q ##4 fetch_q)
        else $error("indirect program access missing extra cycle");
    a_fetch_spacing: assert property (fetch_q |=> !fetch_q [*3])
        else $error("instruction cycles closer than four clocks");
    a_flush_quiet: assert property (flush_q |-> !file_wr_q && !acc_wr_q && !file_rd_q)
        else $error("register strobe in an added cycle");
    a_read_first: assert property ((file_wr_q || acc_wr_q) |-> rd_seen_q)
        else $error("write without the file read before it");
    a_dest_select: assert property (acc_wr_q |-> !dest_file_q && !file_wr_q)
        else $error("accumulator written with destination set to file");
    a_bit_mask: assert property (fetch_q |-> bit_mask_q == (`MASK_ONE << bit_pos_q))
        else $error("bit mask does not match bit field");
endmodule // cpu_instruction_decode_timing

// ### rtl/decode_regs.svh
// named positions, opcode patterns and timing counts for the instruction decoder
`ifndef DECODE_REGS_SVH
`define DECODE_REGS_SVH

// timing
`define OSC_PERIOD_NS 4
`define OSC_PER_INSN 4
`define PHASE_FIRST 2'h0
`define PHASE_RD_SET 2'h0
`define PHASE_WR_SET 2'h2
`define PHASE_LAST 2'h3
`define CYC_ONE 2'h1
`define CYC_TWO 2'h2

// operand fields
`define WORD_W 14
`define F_HI 6
`define F_LO 0
`define D_BIT 7
`define B_HI 9
`define B_LO 7
`define K8_HI 7
`define K11_HI 10
`define PTR_MM_BIT 2
`define PTR_K_BIT 6
`define MM_HI 1
`define MM_LO 0
`define INDIRECT_HI 6
`define INDIRECT_LO 1
`define INDIRECT_BASE 6'h00
`define MASK_ONE 8'h01

// opcode patterns
`define OP_RET_PLAIN 14'h0008
`define OP_RET_INT 14'h0009
`define OP_CALL_ACC 14'h000a
`define OP_JUMP_ACC 14'h000b
`define OP_CALL_TOP 3'h4
`define OP_JUMP_TOP 3'h5
`define OP_RET_LIT 6'h34
`define OP_REL_JUMP 5'h19
`define OP_SKIP_CLR 4'h6
`define OP_SKIP_SET 4'h7
`define OP_DEC_SKIP 6'h0b
`define OP_INC_SKIP 6'h0f
`define OP_PTR_MOVE 10'h001
`define OP_PTR_OFFS 6'h3f
`define OP_BYTE_CLS 2'h0
`define OP_BIT_CLS 2'h1
`define OP_MISC 6'h00
`define OP_BIT_WR 1'h0

`endif

// ### rtl/decode_pkg.sv
// types shared by the decoder and its cycle timer
package decode_pkg;
    typedef logic [13:0] word_t;
    typedef logic [1:0] cycles_t;
    typedef enum logic [1:0] {
        ST_EXEC = 2'b01,
        ST_FLUSH = 2'b10
    } step_e;
endpackage

// ### rtl/timing_if.sv
// carrier between the decoder and its cycle timer
`timescale 1ns/10ps
interface timing_if;
    logic [1:0] phase;
    logic remain_zero;
    logic load;
    decode_pkg::cycles_t cycles;
    modport timer (input load, input cycles, output phase, output remain_zero);
    modport core (output load, output cycles, input phase, input remain_zero);
endinterface

// ### rtl/cycle_timer.sv
// oscillator phase counter and remaining instruction-cycle counter
`timescale 1ns/10ps
`include "decode_regs.svh"
module cycle_timer (
    // clocking
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // decoder side
    timing_if.timer ti
);
    logic [1:0] phase_q, phase_d;
    logic [1:0] remain_q, remain_d;

    always_comb begin
        phase_d = phase_q + 2'h1;
        remain_d = remain_q;
        if (phase_q == `PHASE_LAST) begin
            if (remain_q != 2'h0) begin
                remain_d = remain_q - 2'h1;
            end else if (ti.load) begin
                remain_d = ti.cycles - `CYC_ONE;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase_q <= 2'h0;
            remain_q <= 2'h0;
        end else if (ce) begin
            phase_q <= phase_d;
            remain_q <= remain_d;
        end
    end

    assign ti.phase = phase_q;
    assign ti.remain_zero = (remain_q == 2'h0);

    // four oscillator cycles make one instruction cycle
    a_phase_wrap: assert property (@(posedge clk) disable iff (!rstn || !ce)
        (phase_q == `PHASE_LAST) |=> (phase_q == `PHASE_FIRST))
        else $error("phase did not wrap after four clocks");
endmodule // cycle_timer

// ### dv/prog_store.sv
// program store and register file stand-in on the core side of the decoder
`timescale 1ns/10ps
module prog_store (
    // clocking
    input wire logic clk,
    input wire logic rstn,
    // word the bench wants executed next
    input wire decode_pkg::word_t next_word,
    input wire logic [1:0] next_ptr,
    // decoder side
    input wire logic flush,
    input wire logic file_rd,
    input wire logic file_wr,
    input wire logic acc_wr,
    output decode_pkg::word_t instr_word,
    output logic [1:0] ptr_in_prog,
    // access counts
    output int rd_cnt,
    output int wr_cnt,
    output int acc_cnt,
    output int noop_hits
);
    assign instr_word = next_word;
    assign ptr_in_prog = next_ptr;
    // only accesses are counted; file contents are not modelled, so no data is checked
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_cnt <= 0;
            wr_cnt <= 0;
            acc_cnt <= 0;
            noop_hits <= 0;
        end else begin
            rd_cnt <= rd_cnt + int'(file_rd);
            wr_cnt <= wr_cnt + int'(file_wr);
            acc_cnt <= acc_cnt + int'(acc_wr);
            noop_hits <= noop_hits + int'(flush & (file_rd | file_wr | acc_wr));
        end
    end
endmodule // prog_store

// ### dv/cpu_instruction_decode_timing_bench.sv
// self-checking bench for the instruction decoder and cycle timer
`timescale 1ns/10ps
module cpu_instruction_decode_timing_bench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    decode_pkg::word_t pm_word = 14'h0000;
    logic [1:0] pm_ptr = 2'h0;
    decode_pkg::word_t instr_word, instr_q;
    logic [1:0] ptr_in_prog, ptr_mode_q;
    logic fetch_q, dest_file_q, ptr_num_q, flush_q, file_rd_q, file_wr_q, acc_wr_q;
    logic [6:0] file_addr_q;
    logic [2:0] bit_pos_q;
    logic [7:0] bit_mask_q, literal_q;
    logic [10:0] jump_lit_q;
    decode_pkg::cycles_t cycles_q;
    int rd_cnt, wr_cnt, acc_cnt, noop_hits;
    int fails = 0;
    int n_checks = 0;

    always #2 clk = ~clk;

    cpu_instruction_decode_timing i_dut (.clk(clk), .rstn(rstn), .ce(ce),
        .instr_word(instr_word), .ptr_in_prog(ptr_in_prog), .instr_q(instr_q),
        .fetch_q(fetch_q), .file_addr_q(file_addr_q), .bit_pos_q(bit_pos_q),
        .bit_mask_q(bit_mask_q), .literal_q(literal_q), .jump_lit_q(jump_lit_q),
        .dest_file_q(dest_file_q), .ptr_num_q(ptr_num_q), .ptr_mode_q(ptr_mode_q),
        .cycles_q(cycles_q), .flush_q(flush_q), .file_rd_q(file_rd_q),
        .file_wr_q(file_wr_q), .acc_wr_q(acc_wr_q));

    prog_store i_store (.clk(clk), .rstn(rstn), .next_word(pm_word), .next_ptr(pm_ptr),
        .flush(flush_q), .file_rd(file_rd_q), .file_wr(file_wr_q), .acc_wr(acc_wr_q),
        .instr_word(instr_word), .ptr_in_prog(ptr_in_prog), .rd_cnt(rd_cnt),
        .wr_cnt(wr_cnt), .acc_cnt(acc_cnt), .noop_hits(noop_hits));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, m, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp, input string m);
        n_checks++;
        if (got != exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %0d exp %0d", $time, m, got, exp);
        end
    endtask

    // bounded wait for the next word to be taken
    task automatic wait_fetch();
        for (int k = 0; k < 16; k++) begin
            @(posedge clk);
            #1;
            if (fetch_q === 1'b1)
                return;
        end
        fails++;
        $display("CHECK FAILED at %0t: no fetch", $time);
        wrap_up();
    endtask

    // run one word, then measure its length; a negative write or accumulator count is not checked
    task automatic exec(input decode_pkg::word_t w, input logic [1:0] p, input int cyc,
                        input int rd, input int wr, input int acc);
        int n, nf, r0, w0, a0;
        logic xn;
        logic [1:0] xm;
        pm_word = w;
        pm_ptr = p;
        wait_fetch();
        r0 = rd_cnt;
        w0 = wr_cnt;
        a0 = acc_cnt;
        xn = w[0];
        xm = 2'h0;
        if (w[13:4] == 10'h001) begin
            xn = w[2];
            xm = w[1:0];
        end else if (w[13:8] == 6'h3f)
            xn = w[6];
        chk_val(instr_q, w, "word");
        chk_val(file_addr_q, w[6:0], "file");
        chk_val(dest_file_q, w[7], "dest");
        chk_val(bit_pos_q, w[9:7], "bit");
        chk_val(bit_mask_q, 8'h01 << w[9:7], "mask");
        chk_val(literal_q, w[7:0], "lit");
        chk_val(jump_lit_q, w[10:0], "jlit");
        chk_val(ptr_num_q, xn, "ptr");
        chk_val(ptr_mode_q, xm, "mode");
        chk_val(cycles_q, cyc, "cycles");
        n = 0;
        nf = 0;
        while (n < 16) begin
            @(posedge clk);
            #1;
            n++;
            if (fetch_q === 1'b1)
                break;
            if (flush_q === 1'b1)
                nf++;
        end
        chk_cnt(n, 4 * cyc, "gap");
        chk_cnt(nf, 4 * (cyc - 1), "noop");
        chk_cnt(rd_cnt - r0, rd, "reads");
        if (wr >= 0)
            chk_cnt(wr_cnt - w0, wr, "writes");
        if (acc >= 0)
            chk_cnt(acc_cnt - a0, acc, "acc");
        if (fetch_q !== 1'b1) begin
            fails++;
            $display("CHECK FAILED at %0t: no fetch after instruction", $time);
            wrap_up();
        end
    endtask

    task automatic t_byte();
        exec(14'h07a5, 2'h0, 1, 1, 1, 0);
        exec(14'h0725, 2'h0, 1, 1, 0, 1);
        exec(14'h00a5, 2'h0, 1, 1, 1, 0);
        exec(14'h3000, 2'h0, 1, 0, 0, -1);
        $display("test byte done");
    endtask

    task automatic t_bit();
        exec(14'h13a5, 2'h0, 1, 1, 1, 0);
        exec(14'h1425, 2'h0, 1, 1, 1, 0);
        exec(14'h1990, 2'h0, 2, 1, 0, 0);
        exec(14'h1c10, 2'h0, 2, 1, 0, 0);
        exec(14'h0b90, 2'h0, 2, 1, -1, -1);
        exec(14'h0f10, 2'h0, 2, 1, -1, -1);
        $display("test bit done");
    endtask

    task automatic t_flow();
        decode_pkg::word_t tbl[8] = '{14'h2000, 14'h000a, 14'h0008, 14'h0009, 14'h3400,
                                      14'h2800, 14'h3200, 14'h000b};
        for (int i = 0; i < 8; i++)
            exec(tbl[i], 2'h3, 2, 0, 0, -1);
        $display("test flow done");
    endtask

    task automatic t_indirect();
        exec(14'h0781, 2'h2, 2, 1, 1, 0);
        exec(14'h0781, 2'h1, 1, 1, 1, 0);
        exec(14'h1980, 2'h1, 3, 1, 0, 0);
        exec(14'h3f40, 2'h2, 2, 0, 0, -1);
        exec(14'h0016, 2'h2, 2, 0, 0, -1);
        for (int m = 0; m < 4; m++)
            exec({12'h001, m[1:0]}, 2'h0, 1, 0, 0, -1);
        $display("test indirect done");
    endtask

    // freeze right after a fetch: nothing moves, and the cycle resumes where it stopped
    task automatic t_freeze();
        int n, r0;
        pm_word = 14'h07a5;
        pm_ptr = 2'h0;
        wait_fetch();
        r0 = rd_cnt;
        ce = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        chk_val({fetch_q, file_rd_q, flush_q}, 32'h4, "frozen");
        chk_cnt(rd_cnt - r0, 0, "frozen read");
        ce = 1'b1;
        n = 0;
        while (n < 8) begin
            @(posedge clk);
            #1;
            n++;
            if (fetch_q === 1'b1)
                break;
        end
        chk_cnt(n, 4, "frozen gap");
        chk_cnt(rd_cnt - r0, 1, "resumed read");
        $display("test freeze done");
    endtask

    // second reset in mid-run: the counters restart, so no-op hits are read first
    task automatic t_reset();
        int n;
        chk_cnt(noop_hits, 0, "noop access");
        rstn = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk_val(flush_q, 1'b1, "rst flush");
        chk_val({fetch_q, file_wr_q, cycles_q}, 32'h0, "rst out");
        rstn = 1'b1;
        n = 0;
        while (n < 8) begin
            @(posedge clk);
            #1;
            n++;
            if (fetch_q === 1'b1)
                break;
        end
        chk_cnt(n, 4, "first fetch");
        $display("test reset done");
    endtask

    initial begin
        repeat (20) @(posedge clk);
        #1;
        rstn = 1'b1;
        wait_fetch();
        t_byte();
        t_bit();
        t_flow();
        t_indirect();
        t_freeze();
        t_reset();
        wrap_up();
    end
endmodule // cpu_instruction_decode_timing_bench
